// [hdl/dc_brake_jog_seq.sv]
// dc braking and jog sequencer with axi4-lite settings registers
// assumes one 200 mhz clock, synchronous low reset, async terminal pins
//
// What this block does
// - stop mode 1 selects dc braking stop; brake settings used only then
// - on stop, decelerate and inject dc once at brake start frequency
// - block output for the pre-brake time first, 0.00-60.00 s, reset 0
// - inject stop dc for brake duration, 0.0-60.0 s, reset 1.0
// - stop dc level is brake amount 0-200 percent of rated current
// - brake start frequency up to 60.00 hz, reset 5.00 hz, is threshold
// - skip stop dc injection when brake amount or duration is zero
// - controller gain chosen by inertia setting 0, 1 or 2
// - on start inject start amount for start time, then accelerate
// - skip start dc injection when start amount or time is zero
// - input with function 11 brakes with dc at stop, start amount level
// - every terminal is assignable; three standard, five advanced
// - jog frequency setting, reset 10.00 hz, commands speed during jog
// - input with function 4 runs forward jog while asserted
// - jog frequency confined between start and maximum frequency
// - jog overrides the software target command; no dwell in this block
// - input with function 24 runs forward jog while asserted
// - stop mode 0 ramps to zero; mode 2 cuts output at once
`timescale 1ns/1ps
`include "dcb_params.svh"
module dc_brake_jog_seq #(
   parameter int N_IN = 5, // 3 on standard i/o, 5 on advanced
   parameter int TICK_CYCLES = `DCB_TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [N_IN-1:0] term_pin,
   output logic [15:0] out_freq,
   output logic out_block,
   output logic dc_inject,
   output logic [23:0] dc_current,
   output logic [7:0] dc_gain,
   output logic jog_active
);
   ////////////////////////////////////////////////////////////////////
   // settings registers
   logic run_cmd_r;
   dcb_pkg::stop_mode_t stop_mode_r;
   logic [1:0] inertia_r;
   logic [12:0] preblk_r;
   logic [9:0] stop_dur_r, start_time_r;
   logic [7:0] stop_amt_r, start_amt_r;
   logic [15:0] brk_frq_r, jog_frq_r, start_frq_r, max_frq_r;
   logic [15:0] rated_cur_r, target_r, ramp_r;
   logic [4:0] insel_r [N_IN];
   dcb_pkg::seq_state_t state_r;
   logic [15:0] freq_r;
   logic [12:0] cnt_r;
   logic [N_IN-1:0] term_lvl;

   tick_if ticks ();
   tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .ticks(ticks)
   );
   pin_sync #(.N(N_IN)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(term_pin),
      .level(term_lvl)
   );

   // any asserted terminal assigned the given function
   function automatic logic fn_active(input logic [4:0] code);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < N_IN; k++) begin
         if (term_lvl[k] && insel_r[k] == code) hit = 1'b1;
      end
      return hit;
   endfunction : fn_active

   // register read view; bit 32 flags a mapped offset
   function automatic logic [32:0] reg_read(input logic [7:0] a);
      logic [32:0] v;
      v = {1'b1, 32'h0};
      case (a)
         `DCB_OFS_CTRL: v[4:0] = {inertia_r, stop_mode_r, run_cmd_r};
         `DCB_OFS_PREBLK: v[12:0] = preblk_r;
         `DCB_OFS_STOPDUR: v[9:0] = stop_dur_r;
         `DCB_OFS_STOPAMT: v[7:0] = stop_amt_r;
         `DCB_OFS_BRKFRQ: v[15:0] = brk_frq_r;
         `DCB_OFS_STRTIME: v[9:0] = start_time_r;
         `DCB_OFS_STRAMT: v[7:0] = start_amt_r;
         `DCB_OFS_JOGFRQ: v[15:0] = jog_frq_r;
         `DCB_OFS_STARTFRQ: v[15:0] = start_frq_r;
         `DCB_OFS_MAXFRQ: v[15:0] = max_frq_r;
         `DCB_OFS_RATEDCUR: v[15:0] = rated_cur_r;
         `DCB_OFS_TARGET: v[15:0] = target_r;
         `DCB_OFS_RAMP: v[15:0] = ramp_r;
         `DCB_OFS_INSEL: begin
            for (int k = 0; k < N_IN; k++) begin
               v[k*`DCB_INSEL_W +: `DCB_INSEL_W] = insel_r[k];
            end
         end
         `DCB_OFS_STATUS: v[18:0] = {state_r, freq_r};
         default: v = 33'h0;
      endcase
      return v;
   endfunction : reg_read

   ////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic aw_have_r, w_have_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic [32:0] wr_old;
   logic [31:0] wr_val;
   logic [32:0] rd_view;

   // processes, not assigns, so the reads inside the function wake them
   always_comb wr_old = reg_read(aw_addr_r);
   always_comb rd_view = reg_read({s_axi_araddr[7:2], 2'h0});
   // byte lanes merge over the current contents
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wr_val[b*8 +: 8] = w_strb_r[b] ? w_data_r[b*8 +: 8]
                                        : wr_old[b*8 +: 8];
      end
   end

   // address and data taken in either order, answer once both held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_have_r && w_have_r && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_old[32] ? 2'h0 : 2'h2;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
         end
      end
   end

   // read channel; unmapped offsets answer slverr with zero data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_view[31:0];
            s_axi_rresp <= rd_view[32] ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // settings written when the write answer is raised
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_cmd_r <= 1'b0;
         stop_mode_r <= dcb_pkg::STOP_DECEL;
         inertia_r <= 2'h0;
         preblk_r <= `DCB_RST_PREBLK;
         stop_dur_r <= `DCB_RST_STOPDUR;
         stop_amt_r <= `DCB_RST_STOPAMT;
         brk_frq_r <= `DCB_RST_BRKFRQ;
         start_time_r <= `DCB_RST_STRTIME;
         start_amt_r <= `DCB_RST_STRAMT;
         jog_frq_r <= `DCB_RST_JOGFRQ;
         start_frq_r <= `DCB_RST_STARTFRQ;
         max_frq_r <= `DCB_RST_MAXFRQ;
         rated_cur_r <= `DCB_RST_RATEDCUR;
         target_r <= 16'h0000;
         ramp_r <= `DCB_RST_RAMP;
         for (int k = 0; k < N_IN; k++) insel_r[k] <= 5'(k);
      end else if (aw_have_r && w_have_r && !s_axi_bvalid) begin
         case (aw_addr_r)
            `DCB_OFS_CTRL: begin
               run_cmd_r <= wr_val[`DCB_CTRL_RUN];
               stop_mode_r <= dcb_pkg::stop_mode_t'(
                  wr_val[`DCB_CTRL_MODE_LO +: 2]);
               inertia_r <= wr_val[`DCB_CTRL_INER_LO +: 2];
            end
            `DCB_OFS_PREBLK: preblk_r <= wr_val[12:0];
            `DCB_OFS_STOPDUR: stop_dur_r <= wr_val[9:0];
            `DCB_OFS_STOPAMT: stop_amt_r <= wr_val[7:0];
            `DCB_OFS_BRKFRQ: brk_frq_r <= wr_val[15:0];
            `DCB_OFS_STRTIME: start_time_r <= wr_val[9:0];
            `DCB_OFS_STRAMT: start_amt_r <= wr_val[7:0];
            `DCB_OFS_JOGFRQ: jog_frq_r <= wr_val[15:0];
            `DCB_OFS_STARTFRQ: start_frq_r <= wr_val[15:0];
            `DCB_OFS_MAXFRQ: max_frq_r <= wr_val[15:0];
            `DCB_OFS_RATEDCUR: rated_cur_r <= wr_val[15:0];
            `DCB_OFS_TARGET: target_r <= wr_val[15:0];
            `DCB_OFS_RAMP: ramp_r <= wr_val[15:0];
            `DCB_OFS_INSEL: begin
               for (int k = 0; k < N_IN; k++) begin
                  insel_r[k] <= wr_val[k*`DCB_INSEL_W +: `DCB_INSEL_W];
               end
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // command selection
   logic jog_req, run_req, dc_term_req;
   logic [15:0] cmd_frq, jog_lim, brk_lim;
   logic stop_dc_ok, start_dc_ok;

   // terminal requests; a process so the terminal levels wake it
   always_comb begin
      jog_req = fn_active(`DCB_FN_JOG)
              || fn_active(`DCB_FN_JOGFX);
      dc_term_req = fn_active(`DCB_FN_DCSTOP);
   end
   assign run_req = run_cmd_r || jog_req;
   assign stop_dc_ok = stop_amt_r != 8'h00 && stop_dur_r != 10'h000;
   assign start_dc_ok = start_amt_r != 8'h00
                        && start_time_r != 10'h000;
   // clamp the jog speed between start and maximum frequency
   assign jog_lim = (jog_frq_r < start_frq_r) ? start_frq_r
                  : (jog_frq_r > max_frq_r) ? max_frq_r : jog_frq_r;
   assign brk_lim = (brk_frq_r < start_frq_r) ? start_frq_r : brk_frq_r;
   // jog wins over the software command; no dwell lives in this block
   always_comb begin
      if (jog_req) cmd_frq = jog_lim;
      else if (target_r < start_frq_r) cmd_frq = 16'h0000;
      else if (target_r > max_frq_r) cmd_frq = max_frq_r;
      else cmd_frq = target_r;
   end

   // ramp one step per 0.01 s tick, saturating at the goal
   logic [16:0] up_sum;
   logic [15:0] ramp_up, ramp_dn;
   assign up_sum = {1'b0, freq_r} + {1'b0, ramp_r};
   assign ramp_up = (up_sum >= {1'b0, cmd_frq}) ? cmd_frq : up_sum[15:0];
   assign ramp_dn = (freq_r <= ramp_r) ? 16'h0000 : freq_r - ramp_r;

   ////////////////////////////////////////////////////////////////////
   // sequencer; counts in 0.01 s ticks for block, 0.1 s for injection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= dcb_pkg::ST_IDLE;
         freq_r <= 16'h0000;
         cnt_r <= 13'h0000;
      end else begin
         case (state_r)
            dcb_pkg::ST_IDLE: begin
               freq_r <= 16'h0000;
               if (run_req && start_dc_ok) begin
                  state_r <= dcb_pkg::ST_START_DC;
                  cnt_r <= {3'h0, start_time_r};
               end else if (run_req) begin
                  state_r <= dcb_pkg::ST_RUN;
               end else if (dc_term_req) begin
                  state_r <= dcb_pkg::ST_HOLD_DC;
               end
            end
            dcb_pkg::ST_START_DC: begin
               if (!run_req) state_r <= dcb_pkg::ST_IDLE;
               else if (cnt_r == 13'h0000) state_r <= dcb_pkg::ST_RUN;
               else if (ticks.tick_slow) cnt_r <= cnt_r - 13'h1;
            end
            dcb_pkg::ST_RUN: begin
               if (!run_req) begin
                  // coast drops the output in the same edge
                  if (stop_mode_r == dcb_pkg::STOP_COAST) begin
                     state_r <= dcb_pkg::ST_IDLE;
                     freq_r <= 16'h0000;
                  end else begin
                     state_r <= dcb_pkg::ST_DECEL;
                  end
               end else if (ticks.tick_fast) begin
                  freq_r <= (freq_r < cmd_frq) ? ramp_up
                          : (ramp_dn < cmd_frq) ? cmd_frq : ramp_dn;
               end
            end
            dcb_pkg::ST_DECEL: begin
               if (run_req) begin
                  state_r <= dcb_pkg::ST_RUN;
               end else if (stop_mode_r == dcb_pkg::STOP_DCBRAKE
                            && stop_dc_ok && freq_r <= brk_lim) begin
                  state_r <= dcb_pkg::ST_BLOCK;
                  freq_r <= 16'h0000;
                  cnt_r <= preblk_r;
               end else if (freq_r == 16'h0000) begin
                  state_r <= dcb_pkg::ST_IDLE;
               end else if (ticks.tick_fast) begin
                  freq_r <= ramp_dn;
               end
            end
            dcb_pkg::ST_BLOCK: begin
               if (cnt_r == 13'h0000) begin
                  state_r <= dcb_pkg::ST_STOP_DC;
                  cnt_r <= {3'h0, stop_dur_r};
               end else if (ticks.tick_fast) begin
                  cnt_r <= cnt_r - 13'h1;
               end
            end
            dcb_pkg::ST_STOP_DC: begin
               if (cnt_r == 13'h0000) state_r <= dcb_pkg::ST_IDLE;
               else if (ticks.tick_slow) cnt_r <= cnt_r - 13'h1;
            end
            dcb_pkg::ST_HOLD_DC: begin
               if (run_req || !dc_term_req) state_r <= dcb_pkg::ST_IDLE;
            end
            default: state_r <= dcb_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power stage outputs, all registered
   logic inj_stop, inj_start;
   assign inj_stop = state_r == dcb_pkg::ST_STOP_DC;
   assign inj_start = state_r == dcb_pkg::ST_START_DC
                    || state_r == dcb_pkg::ST_HOLD_DC;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_freq <= 16'h0000;
         out_block <= 1'b1;
         dc_inject <= 1'b0;
         dc_current <= 24'h000000;
         jog_active <= 1'b0;
      end else begin
         out_freq <= freq_r;
         out_block <= state_r == dcb_pkg::ST_IDLE
                   || state_r == dcb_pkg::ST_BLOCK;
         dc_inject <= inj_stop || inj_start;
         // level as amount times rated current, percent units
         if (inj_stop)
            dc_current <= 24'(stop_amt_r) * 24'(rated_cur_r);
         else if (inj_start)
            dc_current <= 24'(start_amt_r) * 24'(rated_cur_r);
         else dc_current <= 24'h000000;
         jog_active <= jog_req && (state_r == dcb_pkg::ST_RUN);
      end
   end

   // brake controller gain from load inertia
   always_ff @(posedge aclk) begin
      if (!aresetn) dc_gain <= `DCB_GAIN_LOW;
      else begin
         case (inertia_r)
            2'h0: dc_gain <= `DCB_GAIN_LOW;
            2'h1: dc_gain <= `DCB_GAIN_MID;
            default: dc_gain <= `DCB_GAIN_HIGH;
         endcase
      end
   end
endmodule : dc_brake_jog_seq

// [inc/dcb_params.svh]
// constants for the dc brake and jog sequencer: offsets, reset values,
// field positions and timing counts; included wherever they are needed
`ifndef DCB_PARAMS_SVH
`define DCB_PARAMS_SVH
// register byte offsets on the axi4-lite slave
`define DCB_OFS_CTRL 8'h00
`define DCB_OFS_PREBLK 8'h04
`define DCB_OFS_STOPDUR 8'h08
`define DCB_OFS_STOPAMT 8'h0c
`define DCB_OFS_BRKFRQ 8'h10
`define DCB_OFS_STRTIME 8'h14
`define DCB_OFS_STRAMT 8'h18
`define DCB_OFS_JOGFRQ 8'h1c
`define DCB_OFS_STARTFRQ 8'h20
`define DCB_OFS_MAXFRQ 8'h24
`define DCB_OFS_RATEDCUR 8'h28
`define DCB_OFS_TARGET 8'h2c
`define DCB_OFS_RAMP 8'h30
`define DCB_OFS_INSEL 8'h34
`define DCB_OFS_STATUS 8'h38
// control word fields
`define DCB_CTRL_RUN 0
`define DCB_CTRL_MODE_LO 1
`define DCB_CTRL_INER_LO 3
`define DCB_INSEL_W 5
// reset values, frequencies in 0.01 hz, times in 0.01 s or 0.1 s
`define DCB_RST_PREBLK 13'h0000
`define DCB_RST_STOPDUR 10'h00a
`define DCB_RST_STOPAMT 8'h32
`define DCB_RST_BRKFRQ 16'h01f4
`define DCB_RST_STRTIME 10'h000
`define DCB_RST_STRAMT 8'h32
`define DCB_RST_JOGFRQ 16'h03e8
`define DCB_RST_STARTFRQ 16'h0032
`define DCB_RST_MAXFRQ 16'h1770
`define DCB_RST_RATEDCUR 16'h0064
`define DCB_RST_RAMP 16'h000a
// input function codes
`define DCB_FN_JOG 5'h04
`define DCB_FN_DCSTOP 5'h0b
`define DCB_FN_JOGFX 5'h18
// controller gain per inertia setting
`define DCB_GAIN_LOW 8'h10
`define DCB_GAIN_MID 8'h20
`define DCB_GAIN_HIGH 8'h40
// base tick: time in ms and clock in mhz give the count
`define DCB_TICK_MS 10
`define DCB_CLK_MHZ 200
`define DCB_TICK_CYCLES (`DCB_TICK_MS * `DCB_CLK_MHZ * 1000)
`define DCB_SLOW_DIV 10
`endif

// [inc/dcb_pkg.sv]
// types for the dc brake and jog sequencer
// assumes nothing beyond a systemverilog compiler
package dcb_pkg;
   typedef enum logic [1:0] {
      STOP_DECEL = 2'h0,
      STOP_DCBRAKE = 2'h1,
      STOP_COAST = 2'h2
   } stop_mode_t;
   // gray coded along idle, start dc, run, decel, block, stop dc
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START_DC = 3'h1,
      ST_RUN = 3'h3,
      ST_DECEL = 3'h2,
      ST_BLOCK = 3'h6,
      ST_STOP_DC = 3'h7,
      ST_HOLD_DC = 3'h5
   } seq_state_t;
endpackage : dcb_pkg

// [inc/tick_if.sv]
// tick enables shared between the divider and the sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface tick_if;
   logic tick_fast; // every 0.01 s
   logic tick_slow; // every 0.1 s
   modport src (output tick_fast, output tick_slow);
   modport dst (input tick_fast, input tick_slow);
endinterface : tick_if

// [hdl/tick_gen.sv]
// divider making the 0.01 s and 0.1 s enable pulses
// assumes aclk at the rate the top passes in as the cycle count
`timescale 1ns/1ps
`include "dcb_params.svh"
module tick_gen #(
   parameter int TICK_CYCLES = `DCB_TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   tick_if.src ticks
);
   logic [31:0] div_r;
   logic [3:0] slow_r;

   // free running divider; first pulse lands within one period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= 32'h0;
         slow_r <= 4'h0;
         ticks.tick_fast <= 1'b0;
         ticks.tick_slow <= 1'b0;
      end else begin
         ticks.tick_fast <= 1'b0;
         ticks.tick_slow <= 1'b0;
         if (div_r == 32'(TICK_CYCLES - 1)) begin
            div_r <= 32'h0;
            ticks.tick_fast <= 1'b1;
            if (slow_r == 4'(`DCB_SLOW_DIV - 1)) begin
               slow_r <= 4'h0;
               ticks.tick_slow <= 1'b1;
            end else begin
               slow_r <= slow_r + 4'h1;
            end
         end else begin
            div_r <= div_r + 32'h1;
         end
      end
   end
endmodule : tick_gen

// [hdl/pin_sync.sv]
// three flop synchroniser with agreement filter for terminal pins
// assumes pins are asynchronous to aclk
`timescale 1ns/1ps
module pin_sync #(
   parameter int N = 5
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [N-1:0] pin,
   output logic [N-1:0] level
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_sync
         logic s1_r, s2_r, s3_r;
         // s1 only feeds s2; a change counts once s2 and s3 agree
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               level[i] <= 1'b0;
            end else begin
               s1_r <= pin[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) level[i] <= s3_r;
            end
         end
      end
   endgenerate
endmodule : pin_sync

// [tb/dcb_chk_sva.sv]
// output checker for the dc brake and jog sequencer
// assumes only the top module ports; bound at the foot of the file
`timescale 1ns/1ps
module dcb_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] out_freq,
   input wire logic out_block,
   input wire logic dc_inject,
   input wire logic [23:0] dc_current,
   input wire logic [7:0] dc_gain,
   input wire logic jog_active
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   // no frequency while blocked or under dc; dc level, gain and jog checked too
   a_block_zero_freq: assert property (
      out_block |-> out_freq == 16'h0000) else $error("freq while blocked");
   a_dc_no_freq: assert property (
      dc_inject |-> out_freq == 16'h0000 && !out_block)
      else $error("freq during dc");
   a_dc_level: assert property (
      dc_inject |-> dc_current != 24'h000000) else $error("zero dc level");
   a_gain_legal: assert property (
      dc_gain inside {8'h10, 8'h20, 8'h40}) else $error("bad gain");
   a_jog_drives: assert property (
      jog_active |-> !out_block) else $error("jog while blocked");
   // bus answers must stand until taken; no new request taken meanwhile
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp dropped");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata dropped");
   a_busy_refuse: assert property (
      (s_axi_bvalid |-> !s_axi_awready) and (s_axi_rvalid |-> !s_axi_arready))
      else $error("accept while busy");
endmodule : dcb_chk
bind dc_brake_jog_seq dcb_chk dcb_chk_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awready(s_axi_awready), .s_axi_arready(s_axi_arready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .out_freq(out_freq), .out_block(out_block), .dc_inject(dc_inject),
   .dc_current(dc_current), .dc_gain(dc_gain), .jog_active(jog_active));

// [tb/dcb_power_stage.sv]
// behavioural power stage and motor shaft
// assumes the sequencer outputs on the same clock
`timescale 1ns/1ps
module dcb_power_stage (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] out_freq,
   input wire logic out_block,
   input wire logic dc_inject,
   input wire logic [23:0] dc_current,
   output logic [15:0] shaft_speed
);
   // shaft follows the drive, coasts when blocked, halts under dc
   always_ff @(posedge aclk) begin
      if (!aresetn)
         shaft_speed <= 16'h0000;
      else if (dc_inject && dc_current != 24'h000000)
         shaft_speed <= 16'h0000;
      else if (!out_block)
         shaft_speed <= out_freq;
   end
endmodule : dcb_power_stage

// [tb/tb_dc_brake_jog_seq.sv]
// self-checking bench for the dc brake and jog sequencer
// assumes checker and power stage model compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
$display("ERROR %0t got %0h exp %0h", $time, g, e); end end
`define WT(c) while (!(c)) @(posedge aclk);
module tb_dc_brake_jog_seq;
   logic aclk, aresetn, awv, wv, bready, arv, rready, bvalid, rvalid;
   logic awr, wr, arr, blk, dci, jog;
   logic [7:0] awa, ara, gain;
   logic [31:0] wd, rd, v;
   logic [4:0] pin;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] frq, shaft;
   logic [23:0] cur;
   logic [4:0] jc [2] = '{5'h04, 5'h18};
   logic [31:0] rv [16] = '{32'h0, 32'h0, 32'ha, 32'h32, 32'h1f4, 32'h0,
      32'h32, 32'h3e8, 32'h32, 32'h1770, 32'h64, 32'h0, 32'ha, 32'h418820,
      32'h0, 32'h0};
   int error_cnt = 0, comparisons = 0, cyc = 0, n;
   dc_brake_jog_seq #(.TICK_CYCLES(8)) dc_brake_jog_seq_inst (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .term_pin(pin), .out_freq(frq), .out_block(blk), .dc_inject(dci),
      .dc_current(cur), .dc_gain(gain), .jog_active(jog));
   dcb_power_stage dcb_power_stage_inst (.aclk(aclk), .aresetn(aresetn),
      .out_freq(frq), .out_block(blk), .dc_inject(dci), .dc_current(cur),
      .shaft_speed(shaft));
   ////////////////////////////////////////////////////////////////////////
   // write: address and data offered together, each dropped once taken
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask : wr32
   task automatic rd32(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rvalid);
      d = rd;
      rs = rresp;
      rready <= 1'b0;
   endtask : rd32
   task automatic final_report;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // watchdog well above the few thousand cycles the run needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      {aresetn, awv, wv, bready, arv, rready} = 6'h00;
      {awa, ara, wd, pin} = 53'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values row by row; target skipped, last row unmapped
      for (int i = 0; i < 16; i++) if (i != 11) begin
         rd32(8'(4 * i), v);
         `CHK(v, rv[i])
         `CHK(rs, (i == 15) ? 2'h2 : 2'h0)
      end
      wr32(8'h3c, 32'h1);
      `CHK(rs, 2'h2)
      for (int k = 0; k < 3; k++) begin
         wr32(8'h00, 32'(k << 3));
         repeat (3) @(posedge aclk);
         `CHK(gain, 8'h10 << k)
      end
      // jog above maximum must be held at maximum, start dc off
      wr32(8'h30, 32'h7d0);
      wr32(8'h1c, 32'h2000);
      foreach (jc[j]) begin
         wr32(8'h34, {27'h0, jc[j]});
         pin <= 5'h01;
         `WT(frq >= 16'h1770)
         repeat (40) @(posedge aclk);
         `CHK(frq, 16'h1770)
         `CHK(jog, 1'b1)
         pin <= 5'h00;
         `WT(blk)
         `CHK(shaft, 16'h0)
      end
      // start dc, run, then dc braking stop
      wr32(8'h14, 32'h2);
      wr32(8'h18, 32'h64);
      wr32(8'h04, 32'h3);
      wr32(8'h2c, 32'hbb8);
      wr32(8'h00, 32'h3);
      `WT(dci)
      `CHK(cur, 24'h2710)
      `WT(frq == 16'h0bb8)
      wr32(8'h00, 32'h2);
      `WT(blk)
      `CHK(frq, 16'h0)
      `WT(dci)
      `CHK(cur, 24'h1388)
      n = 0;
      while (dci) begin n++; @(posedge aclk); end
      `CHK(n > 700 && n < 900, 1'b1)
      `CHK(shaft, 16'h0)
      // zero brake amount: plain ramp, nothing injected after stop
      wr32(8'h0c, 32'h0);
      wr32(8'h00, 32'h3);
      `WT(frq == 16'h0bb8)
      wr32(8'h00, 32'h2);
      n = 0;
      `WT(blk)
      repeat (100) begin n += dci; @(posedge aclk); end
      `CHK(n, 0)
      // coast stop leaves the shaft turning
      wr32(8'h00, 32'h5);
      `WT(frq == 16'h0bb8)
      wr32(8'h00, 32'h4);
      `WT(blk)
      `CHK(frq, 16'h0)
      `CHK(shaft, 16'h0bb8)
      // terminal two asks for dc while stopped
      wr32(8'h34, 32'h160);
      pin <= 5'h02;
      `WT(dci)
      `CHK(cur, 24'h2710)
      // reset in mid-hold drops the dc, blocks, restores settings
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      `CHK({dci, blk, cur}, 26'h1000000)
      aresetn <= 1'b1;
      pin <= 5'h00;
      rd32(8'h34, v);
      `CHK(v, rv[13])
      final_report();
   end
endmodule : tb_dc_brake_jog_seq
